// ### mmd_top.sv
// module: program, external data and internal data space decoder of the mcu
`default_nettype none
// Contract
// - program and data spaces each span 64K
// - internal data space is 256 bytes, 00h-FFh
// - boot fetches come from 4K boot memory
// - boot mode: 8K ram read/write in data space
// - rom disable set: fetch from 8K ram
// - normal mode: boot memory at 8000h
// - normal mode: 8K ram read-only program memory
// - data space holds buffers, configs, setup, registers
// - buffers ram, register region flip-flops
// - special function space 80h-FFh, 128 bytes
// - lower 128 bytes direct and indirect
// - special function space direct only
// - external mode exposes buffers, configs, registers only
// - external mode decodes only A0-A10
// - window aliases at every 2K boundary
module mmd_top import mmd_pkg::*; (
   // clock, reset, enable
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // mode control
   input wire logic rom_disable_set_i,
   input wire logic ext_mode_pin_i,
   // program fetch
   input wire logic pm_fetch_i,
   input wire logic [ADDR_W-1:0] pm_addr_i,
   // external data access from the core
   input wire logic xd_rd_i,
   input wire logic xd_wr_i,
   input wire logic [ADDR_W-1:0] xd_addr_i,
   input wire logic [DATA_W-1:0] xd_wdata_i,
   // internal data access
   input wire logic id_rd_i,
   input wire logic id_wr_i,
   input wire logic id_indirect_i,
   input wire logic [7:0] id_addr_i,
   // external controller pins
   input wire logic ext_rd_pin_i,
   input wire logic ext_wr_pin_i,
   input wire logic [EXT_ADDR_W-1:0] ext_addr_pin_i,
   input wire logic [DATA_W-1:0] ext_wdata_pin_i,
   // mode status
   output logic rom_disable_o,
   output logic ext_active_o,
   // program space selects
   output logic pm_rom_sel_o,
   output logic pm_ram_sel_o,
   output logic pm_miss_o,
   output logic [OFF_W-1:0] pm_off_o,
   // external data space selects
   output logic xd_buf_sel_o,
   output logic xd_setup_sel_o,
   output logic xd_cfg_sel_o,
   output logic xd_mmr_sel_o,
   output logic xd_code_ram_sel_o,
   output logic xd_rd_o,
   output logic xd_wr_o,
   output logic xd_ro_err_o,
   output logic [OFF_W-1:0] xd_off_o,
   output logic [DATA_W-1:0] xd_wdata_o,
   // internal data space selects
   output logic id_ram_sel_o,
   output logic id_sfr_sel_o,
   output logic id_err_o,
   output logic [6:0] id_off_o
);
   // ****************************************
   // pin synchronisation
   // ****************************************
   logic [SYNC_W-1:0] ext_sync;
   logic ext_mode_s;
   logic ext_rd_s;
   logic ext_wr_s;
   logic [EXT_ADDR_W-1:0] ext_addr_s;
   logic [DATA_W-1:0] ext_wdata_s;

   mmd_sync #(.W(SYNC_W)) u_sync (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .d_i({ext_mode_pin_i, ext_rd_pin_i, ext_wr_pin_i, ext_addr_pin_i, ext_wdata_pin_i}),
      .q_o(ext_sync)
   );
   assign {ext_mode_s, ext_rd_s, ext_wr_s, ext_addr_s, ext_wdata_s} = ext_sync;

   // ****************************************
   // mode state
   // ****************************************
   mmd_mode_e mode;
   mmd_mode_e next_mode;
   logic next_ext_active, next_rom_disable;

   always_comb begin
      next_mode = mode;
      if (rom_disable_set_i) begin
         next_mode = MMD_NORMAL;
      end
      next_ext_active = ext_mode_s;
      next_rom_disable = (next_mode == MMD_NORMAL);
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode <= MMD_BOOT;
         ext_active_o <= 1'b0;
         rom_disable_o <= ROM_DISABLE_RST;
      end else if (ce_i) begin
         mode <= next_mode;
         ext_active_o <= next_ext_active;
         rom_disable_o <= next_rom_disable;
      end
   end

   // ****************************************
   // window region matching
   // ****************************************
   // external mode sees only eleven lines; pinning the upper five high makes every
   // 2K image of the window land on the same cells
   logic [ADDR_W-1:0] win_addr;
   logic [NREG-1:0] reg_hit;
   logic [REGION_OFF_W-1:0] reg_off [NREG];
   mmd_dec_if dec_if [NREG] ();

   assign win_addr = ext_active_o ? (WIN_BASE | {5'h00, ext_addr_s}) : xd_addr_i;

   for (genvar g = 0; g < NREG; g++) begin : g_reg
      assign dec_if[g].addr = win_addr;
      assign reg_hit[g] = dec_if[g].hit;
      assign reg_off[g] = dec_if[g].off;
      mmd_region #(.BASE(REGION_BASE[g]), .SIZE(REGION_SIZE[g])) u_region (
         .dec(dec_if[g])
      );
   end

   // ****************************************
   // decode
   // ****************************************
   logic next_pm_rom;
   logic next_pm_ram;
   logic next_pm_miss;
   logic [OFF_W-1:0] next_pm_off;
   logic next_buf;
   logic next_setup;
   logic next_cfg;
   logic next_mmr;
   logic next_code_ram;
   logic next_xrd;
   logic next_xwr;
   logic next_ro_err;
   logic [OFF_W-1:0] next_xoff;
   logic [DATA_W-1:0] next_xwdata;
   logic next_id_ram;
   logic next_id_sfr;
   logic next_id_err;
   logic [6:0] next_id_off;
   logic xacc;
   logic idacc;

   always_comb begin
      next_pm_rom = 1'b0;
      next_pm_ram = 1'b0;
      next_pm_miss = 1'b0;
      next_pm_off = '0;
      // program space: full 16-bit range, unmapped fetches flagged
      if (pm_fetch_i) begin
         if (mode == MMD_BOOT) begin
            if (pm_addr_i < BOOT_ROM_SIZE) begin
               next_pm_rom = 1'b1;
               next_pm_off = {1'b0, pm_addr_i[11:0]};
            end else begin
               next_pm_miss = 1'b1;
            end
         end else if (pm_addr_i < CODE_RAM_SIZE) begin
            next_pm_ram = 1'b1;
            next_pm_off = pm_addr_i[OFF_W-1:0];
         end else if (pm_addr_i[15:12] == BOOT_ROM_HI_BASE[15:12]) begin
            next_pm_rom = 1'b1;
            next_pm_off = {1'b0, pm_addr_i[11:0]};
         end else begin
            next_pm_miss = 1'b1;
         end
      end

      // external data space; core requests are ignored while the outside controller owns it
      xacc = ext_active_o ? (ext_rd_s | ext_wr_s) : (xd_rd_i | xd_wr_i);
      next_xrd = ext_active_o ? ext_rd_s : xd_rd_i;
      next_xwr = ext_active_o ? (ext_wr_s & ~ext_rd_s) : (xd_wr_i & ~xd_rd_i);
      next_xwdata = ext_active_o ? ext_wdata_s : xd_wdata_i;
      next_buf = 1'b0;
      next_setup = 1'b0;
      next_cfg = 1'b0;
      next_mmr = 1'b0;
      next_code_ram = 1'b0;
      next_ro_err = 1'b0;
      next_xoff = '0;
      if (xacc) begin
         if (reg_hit[RG_BUF]) begin
            next_buf = 1'b1;
            next_xoff = {2'b00, reg_off[RG_BUF]};
         end else if (reg_hit[RG_SETUP] && !ext_active_o) begin
            next_setup = 1'b1;
            next_xoff = {2'b00, reg_off[RG_SETUP]};
         end else if (reg_hit[RG_CFG]) begin
            next_cfg = 1'b1;
            next_xoff = {2'b00, reg_off[RG_CFG]};
         end else if (reg_hit[RG_MMR]) begin
            next_mmr = 1'b1;
            next_xoff = {2'b00, reg_off[RG_MMR]};
         end else if (!ext_active_o && xd_addr_i < CODE_RAM_SIZE) begin
            if (mode == MMD_BOOT) begin
               next_code_ram = 1'b1;
               next_xoff = xd_addr_i[OFF_W-1:0];
            end else begin
               next_ro_err = next_xwr;
            end
         end
      end
      if (!(next_buf | next_setup | next_cfg | next_mmr | next_code_ram)) begin
         next_xrd = 1'b0;
         next_xwr = 1'b0;
      end

      // internal data space
      idacc = id_rd_i | id_wr_i;
      next_id_ram = 1'b0;
      next_id_sfr = 1'b0;
      next_id_err = 1'b0;
      next_id_off = id_addr_i[6:0];
      if (idacc) begin
         if (id_addr_i < ID_SFR_BASE) begin
            next_id_ram = 1'b1;
         end else if (!id_indirect_i) begin
            next_id_sfr = 1'b1;
         end else begin
            next_id_err = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pm_rom_sel_o <= 1'b0;
         pm_ram_sel_o <= 1'b0;
         pm_miss_o <= 1'b0;
         pm_off_o <= '0;
         xd_buf_sel_o <= 1'b0;
         xd_setup_sel_o <= 1'b0;
         xd_cfg_sel_o <= 1'b0;
         xd_mmr_sel_o <= 1'b0;
         xd_code_ram_sel_o <= 1'b0;
         xd_rd_o <= 1'b0;
         xd_wr_o <= 1'b0;
         xd_ro_err_o <= 1'b0;
         xd_off_o <= '0;
         xd_wdata_o <= '0;
         id_ram_sel_o <= 1'b0;
         id_sfr_sel_o <= 1'b0;
         id_err_o <= 1'b0;
         id_off_o <= '0;
      end else if (ce_i) begin
         pm_rom_sel_o <= next_pm_rom;
         pm_ram_sel_o <= next_pm_ram;
         pm_miss_o <= next_pm_miss;
         pm_off_o <= next_pm_off;
         xd_buf_sel_o <= next_buf;
         xd_setup_sel_o <= next_setup;
         xd_cfg_sel_o <= next_cfg;
         xd_mmr_sel_o <= next_mmr;
         xd_code_ram_sel_o <= next_code_ram;
         xd_rd_o <= next_xrd;
         xd_wr_o <= next_xwr;
         xd_ro_err_o <= next_ro_err;
         xd_off_o <= next_xoff;
         xd_wdata_o <= next_xwdata;
         id_ram_sel_o <= next_id_ram;
         id_sfr_sel_o <= next_id_sfr;
         id_err_o <= next_id_err;
         id_off_o <= next_id_off;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   boot_fetch_a: assert property (
      ce_i && pm_fetch_i && mode == MMD_BOOT && pm_addr_i < BOOT_ROM_SIZE
      |=> pm_rom_sel_o && !pm_ram_sel_o && pm_off_o == {1'b0, $past(pm_addr_i[11:0])})
      else $error("boot fetch missed the boot memory");
   ram_fetch_a: assert property (
      ce_i && pm_fetch_i && rom_disable_o && pm_addr_i < CODE_RAM_SIZE
      |=> pm_ram_sel_o && !pm_rom_sel_o)
      else $error("normal fetch missed the code ram");
   high_rom_a: assert property (
      ce_i && pm_fetch_i && rom_disable_o && pm_addr_i[15:12] == BOOT_ROM_HI_BASE[15:12]
      |=> pm_rom_sel_o && pm_off_o[11:0] == $past(pm_addr_i[11:0]))
      else $error("boot memory not at 8000h in normal mode");
   boot_write_a: assert property (
      ce_i && xd_wr_i && !xd_rd_i && !ext_active_o && !rom_disable_o
      && xd_addr_i < CODE_RAM_SIZE |=> xd_code_ram_sel_o && xd_wr_o)
      else $error("boot mode write to code ram refused");
   ro_ram_a: assert property (
      ce_i && xd_wr_i && !xd_rd_i && !ext_active_o && rom_disable_o
      && xd_addr_i < CODE_RAM_SIZE |=> xd_ro_err_o && !xd_code_ram_sel_o && !xd_wr_o)
      else $error("code ram writable in normal mode");
   lower_idata_a: assert property (
      ce_i && (id_rd_i || id_wr_i) && !id_addr_i[7]
      |=> id_ram_sel_o && id_off_o == $past(id_addr_i[6:0]))
      else $error("lower internal data not reached");
   sfr_direct_a: assert property (
      ce_i && (id_rd_i || id_wr_i) && id_addr_i[7] && !id_indirect_i |=> id_sfr_sel_o)
      else $error("direct access missed special function space");
   sfr_indirect_a: assert property (
      ce_i && (id_rd_i || id_wr_i) && id_addr_i[7] && id_indirect_i
      |=> !id_sfr_sel_o && !id_ram_sel_o && id_err_o)
      else $error("indirect access reached special function space");
   ext_expose_a: assert property (
      ext_active_o && $past(ext_active_o) |-> !xd_setup_sel_o && !xd_code_ram_sel_o)
      else $error("external mode reached a hidden region");
   ext_alias_a: assert property (
      ce_i && ext_active_o && ext_rd_s && ext_addr_s >= MMR_BASE[REGION_OFF_W-1:0]
      |=> xd_mmr_sel_o && xd_off_o == {2'b00, $past(ext_addr_s) - MMR_BASE[REGION_OFF_W-1:0]})
      else $error("register region not aliased in external mode");
   rom_hold_a: assert property (
      !rom_disable_o && !rom_disable_set_i |=> !rom_disable_o)
      else $error("rom disable bit set without a request");

   boot_fetch_c: cover property (pm_rom_sel_o && !rom_disable_o);
   high_rom_c: cover property (pm_rom_sel_o && rom_disable_o);
   ext_mmr_c: cover property (ext_active_o && xd_mmr_sel_o && xd_wr_o);
   ro_err_c: cover property (xd_ro_err_o);
endmodule
`default_nettype wire

// ### mmd_pkg.sv
// package: address map, widths and region layout of the memory map decoder
`default_nettype none
package mmd_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int OFF_W = 13;
   localparam int EXT_ADDR_W = 11;
   localparam int REGION_OFF_W = 11;
   localparam int SYNC_W = 22;
   // program and external data spaces each span 64K bytes
   localparam logic [16:0] SPACE_SIZE = 17'h1_0000;
   // internal data: 256 bytes, upper half is the special function space
   localparam logic [7:0] ID_LAST = 8'hFF;
   localparam logic [7:0] ID_SFR_BASE = 8'h80;
   // boot memory and code ram
   localparam logic [15:0] BOOT_ROM_SIZE = 16'h1000;
   localparam logic [15:0] CODE_RAM_SIZE = 16'h2000;
   localparam logic [15:0] BOOT_ROM_HI_BASE = 16'h8000;
   // 2K buffer and register window at the top of external data space
   localparam logic [15:0] WIN_BASE = 16'hF800;
   localparam int NREG = 4;
   localparam int RG_BUF = 0;
   localparam int RG_SETUP = 1;
   localparam int RG_CFG = 2;
   localparam int RG_MMR = 3;
   localparam logic [15:0] BUF_BASE = 16'hF800;
   localparam logic [15:0] BUF_SIZE = 16'h0728;
   localparam logic [15:0] SETUP_BASE = 16'hFF28;
   localparam logic [15:0] SETUP_SIZE = 16'h0008;
   localparam logic [15:0] CFG_BASE = 16'hFF30;
   localparam logic [15:0] CFG_SIZE = 16'h0080;
   localparam logic [15:0] MMR_BASE = 16'hFFB0;
   localparam logic [15:0] MMR_SIZE = 16'h0050;
   localparam logic [15:0] REGION_BASE [NREG] = '{BUF_BASE, SETUP_BASE, CFG_BASE, MMR_BASE};
   localparam logic [15:0] REGION_SIZE [NREG] = '{BUF_SIZE, SETUP_SIZE, CFG_SIZE, MMR_SIZE};
   localparam logic ROM_DISABLE_RST = 1'b0;
   typedef enum logic {MMD_BOOT, MMD_NORMAL} mmd_mode_e;
endpackage
`default_nettype wire

// ### mmd_dec_if.sv
// interface: one address-to-region match between the top and a region matcher
`default_nettype none
interface mmd_dec_if;
   import mmd_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic hit;
   logic [REGION_OFF_W-1:0] off;
   modport region (input addr, output hit, output off);
   modport user (output addr, input hit, input off);
endinterface
`default_nettype wire

// ### mmd_sync.sv
// module: two-flop synchroniser for a group of pin inputs
`default_nettype none
module mmd_sync #(
   parameter int W = 1
) (
   // clock, reset and enable
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // pins and synchronised copy
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta <= '0;
         q_o <= '0;
      end else if (ce_i) begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule
`default_nettype wire

// ### mmd_region.sv
// module: matches one address against a base and size and gives the local offset
`default_nettype none
module mmd_region import mmd_pkg::*; #(
   parameter logic [15:0] BASE = 16'h0000,
   parameter logic [15:0] SIZE = 16'h0001
) (
   mmd_dec_if.region dec
);
   logic [16:0] top;
   logic [15:0] diff;
   always_comb begin
      top = {1'b0, BASE} + {1'b0, SIZE};
      diff = dec.addr - BASE;
      dec.hit = (dec.addr >= BASE) && ({1'b0, dec.addr} < top);
      dec.off = diff[REGION_OFF_W-1:0];
   end
endmodule
`default_nettype wire

// ### mmd_ext_mcu.sv
// partner model: external development controller on the eleven address pins
`default_nettype none
module mmd_ext_mcu import mmd_pkg::*; (
   // clock
   input wire logic mclk_i,
   // controller pins
   output logic rd_o,
   output logic wr_o,
   output logic [EXT_ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] wdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      rd_o = 1'b0;
      wr_o = 1'b0;
      addr_o = '0;
      wdata_o = '0;
   end
   // ****************************************
   // access and release
   // ****************************************
   // only the device window is ever addressed, nothing else sits on this bus
   task automatic start(input logic rd, input logic wr, input logic [EXT_ADDR_W-1:0] a);
      @(posedge mclk_i);
      rd_o <= rd;
      wr_o <= wr;
      addr_o <= a;
      wdata_o <= a[7:0];
      // pins held through the sync stages and the decode flop
      repeat (4) @(posedge mclk_i);
      #1;
   endtask
   // released lines carry no pull, so show the inverse instead of the old value
   task automatic stop();
      @(posedge mclk_i);
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      addr_o <= ~addr_o;
      wdata_o <= ~wdata_o;
      repeat (3) @(posedge mclk_i);
   endtask
endmodule
`default_nettype wire

// ### mmd_top_test.sv
// testbench: drives the memory map decoder and checks its region selects
`default_nettype none
module mmd_top_test import mmd_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] XB = 8'h80, XS = 8'h40, XC = 8'h20, XM = 8'h10;
   localparam logic [7:0] XR = 8'h08, RD = 8'h04, WR = 8'h02, ER = 8'h01;
   logic mclk_i = 1'b0, arst_n_i = 1'b0, ce_i = 1'b1;
   logic rom_disable_set_i = 1'b0, ext_mode_pin_i = 1'b0;
   logic pm_fetch_i = 1'b0, xd_rd_i = 1'b0, xd_wr_i = 1'b0;
   logic id_rd_i = 1'b0, id_wr_i = 1'b0, id_indirect_i = 1'b0;
   logic [ADDR_W-1:0] pm_addr_i = '0, xd_addr_i = '0;
   logic [DATA_W-1:0] xd_wdata_i = '0;
   logic [7:0] id_addr_i = '0;
   wire logic ext_rd_pin_i, ext_wr_pin_i;
   wire logic [EXT_ADDR_W-1:0] ext_addr_pin_i;
   wire logic [DATA_W-1:0] ext_wdata_pin_i;
   logic rom_disable_o, ext_active_o, pm_rom_sel_o, pm_ram_sel_o, pm_miss_o;
   logic xd_buf_sel_o, xd_setup_sel_o, xd_cfg_sel_o, xd_mmr_sel_o, xd_code_ram_sel_o;
   logic xd_rd_o, xd_wr_o, xd_ro_err_o, id_ram_sel_o, id_sfr_sel_o, id_err_o;
   logic [OFF_W-1:0] pm_off_o, xd_off_o;
   logic [DATA_W-1:0] xd_wdata_o;
   logic [6:0] id_off_o;
   logic [7:0] xs;
   logic [2:0] ps, is;
   int error_cnt = 0;
   int check_count = 0;
   assign xs = {xd_buf_sel_o, xd_setup_sel_o, xd_cfg_sel_o, xd_mmr_sel_o, xd_code_ram_sel_o,
      xd_rd_o, xd_wr_o, xd_ro_err_o};
   assign ps = {pm_rom_sel_o, pm_ram_sel_o, pm_miss_o};
   assign is = {id_ram_sel_o, id_sfr_sel_o, id_err_o};
   initial begin
      forever #4 mclk_i = ~mclk_i;
   end
   mmd_top i_dut (.mclk_i, .arst_n_i, .ce_i, .rom_disable_set_i, .ext_mode_pin_i, .pm_fetch_i,
      .pm_addr_i, .xd_rd_i, .xd_wr_i, .xd_addr_i, .xd_wdata_i, .id_rd_i, .id_wr_i,
      .id_indirect_i, .id_addr_i, .ext_rd_pin_i, .ext_wr_pin_i, .ext_addr_pin_i,
      .ext_wdata_pin_i, .rom_disable_o, .ext_active_o, .pm_rom_sel_o, .pm_ram_sel_o,
      .pm_miss_o, .pm_off_o, .xd_buf_sel_o, .xd_setup_sel_o, .xd_cfg_sel_o, .xd_mmr_sel_o,
      .xd_code_ram_sel_o, .xd_rd_o, .xd_wr_o, .xd_ro_err_o, .xd_off_o, .xd_wdata_o,
      .id_ram_sel_o, .id_sfr_sel_o, .id_err_o, .id_off_o);
   mmd_ext_mcu i_ext (.mclk_i(mclk_i), .rd_o(ext_rd_pin_i), .wr_o(ext_wr_pin_i),
      .addr_o(ext_addr_pin_i), .wdata_o(ext_wdata_pin_i));
   // ****************************************
   // compare, access and report tasks
   // ****************************************
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // offset is only meaningful while some region is selected
   task automatic xd_case(input logic r, input logic w, input logic [15:0] a,
      input logic [7:0] es, input logic [15:0] eo);
      @(posedge mclk_i);
      xd_rd_i <= r;
      xd_wr_i <= w;
      xd_addr_i <= a;
      xd_wdata_i <= a[7:0] ^ 8'hA5;
      @(posedge mclk_i);
      xd_rd_i <= 1'b0;
      xd_wr_i <= 1'b0;
      #1;
      chk("xd selects", 16'(es), 16'(xs));
      if (es[7:3] != 5'h00) chk("xd offset", eo, 16'(xd_off_o));
      // in external mode the write data follows the controller's pins, not the core
      chk("xd wdata", ext_mode_pin_i ? 16'(ext_wdata_pin_i) : 16'(a[7:0] ^ 8'hA5),
         16'(xd_wdata_o));
   endtask
   task automatic pm_case(input logic [15:0] a, input logic [2:0] es, input logic [15:0] eo);
      @(posedge mclk_i);
      pm_fetch_i <= 1'b1;
      pm_addr_i <= a;
      @(posedge mclk_i);
      pm_fetch_i <= 1'b0;
      #1;
      chk("pm selects", 16'(es), 16'(ps));
      chk("pm offset", eo, 16'(pm_off_o));
   endtask
   task automatic id_case(input logic w, input logic ind, input logic [7:0] a,
      input logic [2:0] es);
      @(posedge mclk_i);
      id_rd_i <= ~w;
      id_wr_i <= w;
      id_indirect_i <= ind;
      id_addr_i <= a;
      @(posedge mclk_i);
      id_rd_i <= 1'b0;
      id_wr_i <= 1'b0;
      #1;
      chk("id selects", 16'(es), 16'(is));
      chk("id offset", 16'(a[6:0]), 16'(id_off_o));
   endtask
   task automatic ext_case(input logic r, input logic w, input logic [10:0] a,
      input logic [7:0] es, input logic [15:0] eo);
      i_ext.start(r, w, a);
      chk("ext selects", 16'(es), 16'(xs));
      if (es[7:3] != 5'h00) chk("ext offset", eo, 16'(xd_off_o));
      chk("ext wdata", 16'(a[7:0]), 16'(xd_wdata_o));
      i_ext.stop();
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      @(posedge mclk_i);
      arst_n_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      #1;
      chk("outputs in reset", 16'h0000, 16'({rom_disable_o, ext_active_o, xs, ps, is}));
      @(posedge mclk_i);
      arst_n_i <= 1'b1;
   endtask
   task automatic t_boot();
      pm_case(16'h0123, 3'b100, 16'h0123);
      pm_case(BOOT_ROM_SIZE - 16'h0001, 3'b100, 16'h0FFF);
      pm_case(BOOT_ROM_SIZE, 3'b001, 16'h0000);
      pm_case(BOOT_ROM_HI_BASE, 3'b001, 16'h0000);
      xd_case(1'b0, 1'b1, CODE_RAM_SIZE - 16'h0001, XR | WR, 16'h1FFF);
      xd_case(1'b1, 1'b0, 16'h0000, XR | RD, 16'h0000);
      xd_case(1'b1, 1'b0, CODE_RAM_SIZE, 8'h00, 16'h0000);
      xd_case(1'b0, 1'b1, BUF_BASE, XB | WR, 16'h0000);
      xd_case(1'b1, 1'b0, BUF_BASE + BUF_SIZE - 16'h0001, XB | RD, 16'h0727);
      xd_case(1'b1, 1'b0, SETUP_BASE, XS | RD, 16'h0000);
      xd_case(1'b0, 1'b1, SETUP_BASE + 16'h0007, XS | WR, 16'h0007);
      xd_case(1'b0, 1'b1, CFG_BASE + CFG_SIZE - 16'h0001, XC | WR, 16'h007F);
      xd_case(1'b1, 1'b0, MMR_BASE, XM | RD, 16'h0000);
      xd_case(1'b1, 1'b1, 16'hFFFF, XM | RD, MMR_SIZE - 16'h0001);
      xd_case(1'b0, 1'b1, 16'h4000, 8'h00, 16'h0000);
      id_case(1'b0, 1'b0, 8'h00, 3'b100);
      id_case(1'b1, 1'b1, 8'h7F, 3'b100);
      id_case(1'b1, 1'b0, ID_SFR_BASE, 3'b010);
      id_case(1'b0, 1'b0, ID_LAST, 3'b010);
      id_case(1'b1, 1'b1, 8'h80, 3'b001);
      id_case(1'b0, 1'b1, 8'hFF, 3'b001);
   endtask
   // a fetch held while the enable is low must leave every select frozen
   task automatic t_freeze();
      @(posedge mclk_i);
      ce_i <= 1'b0;
      pm_fetch_i <= 1'b1;
      pm_addr_i <= 16'h0123;
      repeat (2) @(posedge mclk_i);
      #1;
      chk("frozen selects", 16'h0000, 16'({ps, xs, is}));
      @(posedge mclk_i);
      ce_i <= 1'b1;
      pm_fetch_i <= 1'b0;
   endtask
   task automatic t_normal();
      @(posedge mclk_i);
      rom_disable_set_i <= 1'b1;
      @(posedge mclk_i);
      rom_disable_set_i <= 1'b0;
      #1;
      chk("rom disable", 16'h0001, 16'(rom_disable_o));
      pm_case(16'h0000, 3'b010, 16'h0000);
      pm_case(CODE_RAM_SIZE - 16'h0001, 3'b010, 16'h1FFF);
      pm_case(CODE_RAM_SIZE, 3'b001, 16'h0000);
      pm_case(BOOT_ROM_HI_BASE, 3'b100, 16'h0000);
      pm_case(16'h8FFF, 3'b100, 16'h0FFF);
      pm_case(16'h9000, 3'b001, 16'h0000);
      xd_case(1'b0, 1'b1, 16'h0010, ER, 16'h0000);
      xd_case(1'b1, 1'b0, 16'h0010, 8'h00, 16'h0000);
      xd_case(1'b0, 1'b1, MMR_BASE + 16'h0004, XM | WR, 16'h0004);
   endtask
   task automatic t_ext();
      int n;
      @(posedge mclk_i);
      ext_mode_pin_i <= 1'b1;
      n = 0;
      while (ext_active_o !== 1'b1 && n < 8) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      chk("ext active", 16'h0001, 16'(ext_active_o));
      if (ext_active_o !== 1'b1) summarize();
      xd_case(1'b1, 1'b0, MMR_BASE, 8'h00, 16'h0000);
      ext_case(1'b1, 1'b0, 11'h7B0, XM | RD, 16'h0000);
      ext_case(1'b0, 1'b1, 11'h7B4, XM | WR, 16'h0004);
      ext_case(1'b1, 1'b0, 11'h7FF, XM | RD, 16'h004F);
      ext_case(1'b1, 1'b0, 11'h000, XB | RD, 16'h0000);
      ext_case(1'b0, 1'b1, 11'h727, XB | WR, 16'h0727);
      ext_case(1'b1, 1'b0, 11'h728, 8'h00, 16'h0000);
      ext_case(1'b0, 1'b1, 11'h72F, 8'h00, 16'h0000);
      ext_case(1'b1, 1'b0, 11'h730, XC | RD, 16'h0000);
   endtask
   initial begin
      repeat (20000) @(posedge mclk_i);
      error_cnt++;
      $display("[ERR] run length expected end seen hang");
      summarize();
   end
   initial begin
      t_reset();
      t_boot();
      t_freeze();
      t_normal();
      t_reset();
      pm_case(16'h0123, 3'b100, 16'h0123);
      t_ext();
      summarize();
   end
endmodule
`default_nettype wire
